/* hw/mdpt_map.vh */
`ifndef MDPT_MAP_VH
`define MDPT_MAP_VH
// =====================================================================
// Timing at 25 MHz reference clock (40 ns period)
`define MDPT_TICK_W 15
// Last count of the 2500-cycle current period (100 us)
`define MDPT_CUR_LAST 15'h09c3
// Last step of the divide-by-ten speed period (1 ms)
`define MDPT_SPD_DIV_LAST 4'h9
// Phase and gate counts
`define MDPT_N_PH 3
`define MDPT_N_GATE 6
// =====================================================================
// Speed limits, rpm (unsigned magnitude, 12 bits)
`define MDPT_SPD_W 12
`define MDPT_SPD_CMD_MAX 12'h4e5
`define MDPT_SPD_OPEN_MAX 12'h177
`define MDPT_SPD_TRIP 12'h9ca
// =====================================================================
// Bus voltage in volts, current magnitude in 10 mA units
`define MDPT_VBUS_W 10
`define MDPT_VBUS_OV 10'h0a0
`define MDPT_VBUS_UV 10'h06e
`define MDPT_CUR_W 10
`define MDPT_CUR_SW_TRIP 10'h0c8
`define MDPT_CUR_HW_TRIP 10'h168
// =====================================================================
// Fault status bit positions
`define MDPT_FLT_W 7
`define MDPT_FLT_OV 0
`define MDPT_FLT_UV 1
`define MDPT_FLT_SPD 2
`define MDPT_FLT_SWOC 3
`define MDPT_FLT_HWOC 4
`define MDPT_FLT_PIN 5
`define MDPT_FLT_IPD 6
`endif

/* hw/mdpt_protect.v */
`timescale 1ns/1ps
`include "mdpt_map.vh"
module mdpt_protect (
  input wire i_ref_clk,
  input wire i_resetn,
  input wire [5:0] i_gate_cmd,
  input wire [`MDPT_SPD_W-1:0] i_speed_cmd,
  input wire i_speed_cmd_ccw,
  input wire [`MDPT_SPD_W-1:0] i_speed_est,
  input wire [`MDPT_VBUS_W-1:0] i_vbus,
  input wire [`MDPT_CUR_W-1:0] i_cur_u,
  input wire [`MDPT_CUR_W-1:0] i_cur_v,
  input wire [`MDPT_CUR_W-1:0] i_cur_w,
  input wire i_meas_valid,
  input wire i_three_shunt,
  input wire i_overcurrent_comparator_out,
  input wire i_external_overcurrent_irq,
  input wire i_position_detect_active,
  input wire i_position_detect_timer_ovf,
  input wire i_fault_clear,
  output reg [5:0] o_gate,
  output reg o_cur_tick,
  output reg o_spd_tick,
  output reg [`MDPT_SPD_W-1:0] o_speed_ref,
  output reg o_speed_ref_ccw,
  output reg o_open_loop,
  output reg o_fault,
  output reg [`MDPT_FLT_W-1:0] o_fault_cause
);

  // =====================================================================
  // Loop cadence
  localparam [`MDPT_TICK_W-1:0] CUR_LAST = `MDPT_CUR_LAST;
  localparam [3:0] SPD_DIV_LAST = `MDPT_SPD_DIV_LAST;

  // Counter state and next values
  reg [`MDPT_TICK_W-1:0] cur_cnt_reg;
  reg [`MDPT_TICK_W-1:0] cur_cnt_next;
  reg [3:0] spd_div_reg;
  reg [3:0] spd_div_next;
  reg cur_tick_next;
  reg spd_tick_next;

  // Current loop counter wraps after the last cycle of its period
  always @*
  begin
    cur_cnt_next = cur_cnt_reg + 1'b1;
    cur_tick_next = 1'b0;
    if (cur_cnt_reg == CUR_LAST)
    begin
      cur_cnt_next = {`MDPT_TICK_W{1'b0}};
      cur_tick_next = 1'b1;
    end
  end

  // Speed divider steps once per current tick and fires on the tenth
  always @*
  begin
    spd_div_next = spd_div_reg;
    spd_tick_next = 1'b0;
    if (cur_tick_next)
    begin
      if (spd_div_reg == SPD_DIV_LAST)
      begin
        spd_div_next = 4'h0;
        spd_tick_next = 1'b1;
      end
      else
      begin
        spd_div_next = spd_div_reg + 1'b1;
      end
    end
  end

  // Current loop counter register
  always @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      cur_cnt_reg <= {`MDPT_TICK_W{1'b0}};
    else
      cur_cnt_reg <= cur_cnt_next;
  end

  // Speed divider register
  always @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      spd_div_reg <= 4'h0;
    else
      spd_div_reg <= spd_div_next;
  end

  // Current loop tick, one cycle wide
  always @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_cur_tick <= 1'b0;
    else
      o_cur_tick <= cur_tick_next;
  end

  // Speed loop tick, one cycle wide, lands with every tenth current tick
  always @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_spd_tick <= 1'b0;
    else
      o_spd_tick <= spd_tick_next;
  end

  // =====================================================================
  // Speed reference, taken on the speed tick
  // Next values for the reference and the drive mode
  reg [`MDPT_SPD_W-1:0] speed_ref_next;
  reg open_loop_next;

  // Command magnitude clamped to the supported range
  always @*
  begin
    if (i_speed_cmd > `MDPT_SPD_CMD_MAX)
      speed_ref_next = `MDPT_SPD_CMD_MAX;
    else
      speed_ref_next = i_speed_cmd;
  end

  // Speed reference magnitude register
  always @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_speed_ref <= {`MDPT_SPD_W{1'b0}};
    else if (spd_tick_next)
      o_speed_ref <= speed_ref_next;
  end

  // Direction, taken together with the magnitude
  always @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_speed_ref_ccw <= 1'b0;
    else if (spd_tick_next)
      o_speed_ref_ccw <= i_speed_cmd_ccw;
  end

  // =====================================================================
  // Drive mode
  // Open loop while the estimate sits at or below the handover speed
  always @*
  begin
    open_loop_next = (i_speed_est <= `MDPT_SPD_OPEN_MAX);
  end

  // Mode register; open loop out of reset, before any estimate exists
  always @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_open_loop <= 1'b1;
    else if (spd_tick_next)
      o_open_loop <= open_loop_next;
  end

  // =====================================================================
  // Per-phase overcurrent compare
  // Packed currents and per-phase results
  wire [`MDPT_N_PH*`MDPT_CUR_W-1:0] cur_all;
  wire [`MDPT_N_PH-1:0] sw_oc;
  wire [`MDPT_N_PH-1:0] hw_oc;

  // Phase currents packed as u, v, w from low to high
  assign cur_all = {i_cur_w, i_cur_v, i_cur_u};

  // One pair of magnitude compares per phase
  genvar ph;
  generate
    for (ph = 0; ph < `MDPT_N_PH; ph = ph + 1)
    begin : g_phase
      wire [`MDPT_CUR_W-1:0] cur_ph;
      assign cur_ph = cur_all[ph*`MDPT_CUR_W +: `MDPT_CUR_W];
      assign sw_oc[ph] = (cur_ph > `MDPT_CUR_SW_TRIP);
      assign hw_oc[ph] = (cur_ph > `MDPT_CUR_HW_TRIP);
    end
  endgenerate

  // =====================================================================
  // Sampled trips, live only while the measurements are valid
  // One flag per sampled check
  wire meas_ov;
  wire meas_uv;
  wire meas_spd;
  wire meas_swoc;
  wire meas_hwoc;

  // Bus voltage above the upper limit
  assign meas_ov = i_meas_valid & (i_vbus > `MDPT_VBUS_OV);

  // Bus voltage below the lower limit
  assign meas_uv = i_meas_valid & (i_vbus < `MDPT_VBUS_UV);

  // Estimated speed beyond the trip speed
  assign meas_spd = i_meas_valid & (i_speed_est > `MDPT_SPD_TRIP);

  // Any phase over the firmware current limit
  assign meas_swoc = i_meas_valid & (|sw_oc);

  // Any phase over the forced cut-off limit; the lower bit sets as well
  assign meas_hwoc = i_meas_valid & (|hw_oc);

  // =====================================================================
  // Pin and timer trips, live regardless of the measurements
  // One flag per live source
  wire pin_trip;
  wire ipd_trip;

  // Low level selects single-shunt, so the comparator is the default source
  assign pin_trip = i_three_shunt ? i_external_overcurrent_irq
                                  : i_overcurrent_comparator_out;

  // Timer overflow only counts while position detection runs
  assign ipd_trip = i_position_detect_active & i_position_detect_timer_ovf;

  // =====================================================================
  // Trip vector in fault cause order
  // All trips seen this cycle
  wire [`MDPT_FLT_W-1:0] trip_now;

  // One bit per cause
  assign trip_now[`MDPT_FLT_OV] = meas_ov;
  assign trip_now[`MDPT_FLT_UV] = meas_uv;
  assign trip_now[`MDPT_FLT_SPD] = meas_spd;
  assign trip_now[`MDPT_FLT_SWOC] = meas_swoc;
  assign trip_now[`MDPT_FLT_HWOC] = meas_hwoc;
  assign trip_now[`MDPT_FLT_PIN] = pin_trip;
  assign trip_now[`MDPT_FLT_IPD] = ipd_trip;

  // =====================================================================
  // Sticky fault causes
  // Next value of every cause bit
  wire [`MDPT_FLT_W-1:0] cause_next;

  // A cause sets on its trip; a clear drops it only while its trip is idle
  genvar fb;
  generate
    for (fb = 0; fb < `MDPT_FLT_W; fb = fb + 1)
    begin : g_cause
      assign cause_next[fb] = trip_now[fb] | (o_fault_cause[fb] & ~i_fault_clear);
    end
  endgenerate

  // Cause register
  always @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_fault_cause <= {`MDPT_FLT_W{1'b0}};
    else
      o_fault_cause <= cause_next;
  end

  // Summary flag follows the next cause value, so it rises with the trip
  always @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_fault <= 1'b0;
    else
      o_fault <= |cause_next;
  end

  // =====================================================================
  // Gate outputs
  // Per-gate next values and the common block
  wire [`MDPT_N_GATE-1:0] gate_next;
  wire gate_block;

  // Any set or arriving cause blocks every gate together
  assign gate_block = |cause_next;

  // Each gate passes the firmware demand unless blocked
  genvar gt;
  generate
    for (gt = 0; gt < `MDPT_N_GATE; gt = gt + 1)
    begin : g_gate
      assign gate_next[gt] = i_gate_cmd[gt] & ~gate_block;
    end
  endgenerate

  // Gate register; all gates low in reset
  always @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_gate <= {`MDPT_N_GATE{1'b0}};
    else
      o_gate <= gate_next;
  end

endmodule // mdpt_protect

/* tb/mdpt_sva.sv */
`timescale 1ns/1ps
// ==========
// Protection checker on the block ports
module mdpt_sva (
  input wire i_ref_clk, input wire i_resetn, input wire [11:0] i_speed_est,
  input wire [9:0] i_vbus, input wire i_meas_valid, input wire i_three_shunt,
  input wire i_overcurrent_comparator_out, input wire i_external_overcurrent_irq,
  input wire i_position_detect_active, input wire i_position_detect_timer_ovf,
  input wire i_fault_clear, input wire [5:0] o_gate, input wire o_spd_tick,
  input wire o_open_loop, input wire o_fault, input wire [6:0] o_fault_cause
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  // Voltage, speed and timer causes latch one cycle after they are seen; pin trips drop the gates
  AST_OV: assert property (i_meas_valid && i_vbus > 10'h0a0 |=> o_fault_cause[0])
    else $error("ov");
  AST_UV: assert property (i_meas_valid && i_vbus < 10'h06e |=> o_fault_cause[1])
    else $error("uv");
  AST_SPD: assert property (i_meas_valid && i_speed_est > 12'h9ca |=> o_fault_cause[2])
    else $error("spd");
  AST_CMP: assert property (!i_three_shunt && i_overcurrent_comparator_out |=> !o_gate)
    else $error("cmp");
  AST_IRQ: assert property (i_three_shunt && i_external_overcurrent_irq |=> !o_gate)
    else $error("irq");
  AST_IPD: assert property (i_position_detect_active && i_position_detect_timer_ovf
    |=> o_fault_cause[6]) else $error("ipd");
  // Latched fault keeps all gates off until cleared
  AST_HOLD: assert property (o_fault && !i_fault_clear |=> o_fault && !o_gate)
    else $error("hold");
  AST_OPEN: assert property (o_spd_tick |-> o_open_loop == ($past(i_speed_est) <= 12'h177))
    else $error("open");
  // Main scenarios reached
  cover property (o_spd_tick);
  cover property (o_fault_cause[4]);
  cover property ($fell(o_fault));
endmodule // mdpt_sva
bind mdpt_protect mdpt_sva chk_u (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
  .i_speed_est(i_speed_est), .i_vbus(i_vbus), .i_meas_valid(i_meas_valid),
  .i_three_shunt(i_three_shunt), .i_overcurrent_comparator_out(i_overcurrent_comparator_out),
  .i_external_overcurrent_irq(i_external_overcurrent_irq),
  .i_position_detect_active(i_position_detect_active),
  .i_position_detect_timer_ovf(i_position_detect_timer_ovf), .i_fault_clear(i_fault_clear),
  .o_gate(o_gate), .o_spd_tick(o_spd_tick), .o_open_loop(o_open_loop), .o_fault(o_fault),
  .o_fault_cause(o_fault_cause));

/* tb/mdpt_inv_model.sv */
`timescale 1ns/1ps
// ==========
// Inverter current sensing seen from the gates
module mdpt_inv_model (
  input wire i_ref_clk, input wire [5:0] i_gate, input wire [9:0] i_load,
  output reg [9:0] o_cur, output reg o_cmp
);
  // Current flows only while a gate conducts; comparator above 3.6 A
  always @(posedge i_ref_clk)
  begin
    o_cur <= |i_gate ? i_load : 10'h000;
    o_cmp <= |i_gate && i_load > 10'h168;
  end
endmodule // mdpt_inv_model

/* tb/mdpt_protect_tb.sv */
`timescale 1ns/1ps
// ==========
// Self-checking bench for the protection block
module mdpt_protect_tb;
  reg i_ref_clk, i_resetn, i_speed_cmd_ccw, i_meas_valid, i_three_shunt, i_fault_clear;
  reg i_external_overcurrent_irq, i_position_detect_active, i_position_detect_timer_ovf;
  reg [5:0] i_gate_cmd;
  reg [11:0] i_speed_cmd, i_speed_est;
  reg [9:0] i_vbus, ld;
  wire [9:0] i_cur_u, i_cur_v = i_cur_u, i_cur_w = i_cur_u;
  wire [5:0] o_gate;
  wire [11:0] o_speed_ref;
  wire [6:0] o_fault_cause;
  wire i_overcurrent_comparator_out, o_cur_tick, o_spd_tick, o_speed_ref_ccw, o_open_loop, o_fault;
  integer seed, error_cnt, n_checks, i, n;
  mdpt_protect dut_u (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_gate_cmd(i_gate_cmd),
    .i_speed_cmd(i_speed_cmd), .i_speed_cmd_ccw(i_speed_cmd_ccw), .i_speed_est(i_speed_est),
    .i_vbus(i_vbus), .i_cur_u(i_cur_u), .i_cur_v(i_cur_v), .i_cur_w(i_cur_w),
    .i_meas_valid(i_meas_valid), .i_three_shunt(i_three_shunt),
    .i_overcurrent_comparator_out(i_overcurrent_comparator_out),
    .i_external_overcurrent_irq(i_external_overcurrent_irq),
    .i_position_detect_active(i_position_detect_active),
    .i_position_detect_timer_ovf(i_position_detect_timer_ovf), .i_fault_clear(i_fault_clear),
    .o_gate(o_gate), .o_cur_tick(o_cur_tick), .o_spd_tick(o_spd_tick),
    .o_speed_ref(o_speed_ref), .o_speed_ref_ccw(o_speed_ref_ccw), .o_open_loop(o_open_loop),
    .o_fault(o_fault), .o_fault_cause(o_fault_cause));
  mdpt_inv_model inv_u (.i_ref_clk(i_ref_clk), .i_gate(o_gate), .i_load(ld), .o_cur(i_cur_u),
    .o_cmp(i_overcurrent_comparator_out));
  // 25 MHz clock
  initial
  begin
    i_ref_clk = 0;
    forever #20 i_ref_clk = ~i_ref_clk;
  end
  // Expected clamp and trip pattern
  function [11:0] exp_ref(input [11:0] c);
    exp_ref = c > 12'h4e5 ? 12'h4e5 : c;
  endfunction
  function [6:0] msk(input integer k);
    msk = k == 4 ? 7'h38 : k == 5 ? 7'h20 : k > 6 ? 7'h00 : 7'h01 << k;
  endfunction
  task chk(input [15:0] got, input [15:0] exp);
  begin
    n_checks = n_checks + 1;
    if (got !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  task wrap_up;
  begin
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask
  // Bounded wait for a tick, cycles counted in n
  task wtk(input cur);
  begin
    n = 0;
    do
    begin
      @(negedge i_ref_clk);
      n = n + 1;
    end while ((cur ? o_cur_tick : o_spd_tick) !== 1'b1 && n < 26000);
    if (n >= 26000)
    begin
      error_cnt = error_cnt + 1;
      wrap_up;
    end
  end
  endtask
  // Main sequence
  initial
  begin
    seed = 73; error_cnt = 0; n_checks = 0; i_resetn = 0; i_gate_cmd = 6'h15; i_fault_clear = 0;
    {i_speed_cmd, i_speed_cmd_ccw, i_three_shunt, i_external_overcurrent_irq} = 0;
    {i_position_detect_active, i_position_detect_timer_ovf} = 0;
    i_meas_valid = 1; i_vbus = 10'h08d; i_speed_est = 12'h064; ld = 10'h064;
    repeat (6) @(posedge i_ref_clk);
    i_resetn <= 1;
    wtk(1);
    wtk(1);
    chk(n, 2500);
    for (i = 0; i < 8; i = i + 1)
    begin
      @(posedge i_ref_clk);
      i_gate_cmd <= $random(seed) | 1;
      case (i)
        0: i_vbus <= 10'h0a1;
        1: i_vbus <= 10'h06d;
        2: i_speed_est <= 12'h9cb;
        3: ld <= 10'h0c9;
        4: ld <= 10'h169;
        5: {i_three_shunt, i_external_overcurrent_irq} <= 2'h3;
        6: {i_position_detect_active, i_position_detect_timer_ovf} <= 2'h3;
        default: {i_meas_valid, i_vbus} <= 11'h3ff;
      endcase
      repeat (4) @(negedge i_ref_clk);
      chk(o_fault_cause, msk(i));
      chk(o_gate, msk(i) ? 6'h00 : i_gate_cmd);
      @(posedge i_ref_clk);
      i_fault_clear <= 1;
      @(posedge i_ref_clk);
      i_fault_clear <= 0;
      @(negedge i_ref_clk);
      chk(o_fault_cause, i == 3 || i == 4 ? 7'h00 : msk(i));
      @(posedge i_ref_clk);
      {i_three_shunt, i_external_overcurrent_irq, i_position_detect_active} <= 0;
      {i_position_detect_timer_ovf, i_meas_valid, i_vbus} <= {2'h1, 10'h08d};
      {i_speed_est, ld} <= {12'h064, 10'h064};
      repeat (2) @(posedge i_ref_clk);
      i_fault_clear <= 1;
      @(posedge i_ref_clk);
      i_fault_clear <= 0;
      repeat (2) @(negedge i_ref_clk);
      chk({o_fault, o_gate}, {1'b0, i_gate_cmd});
    end
    wtk(0);
    for (i = 0; i < 2; i = i + 1)
    begin
      @(posedge i_ref_clk);
      i_speed_cmd <= i ? $random(seed) : 12'h4e6;
      i_speed_est <= i ? 12'h178 : 12'h177;
      i_speed_cmd_ccw <= i[0];
      wtk(0);
      chk(n, 25000);
      chk({o_speed_ref_ccw, o_speed_ref}, {i_speed_cmd_ccw, exp_ref(i_speed_cmd)});
      chk(o_open_loop, i_speed_est <= 12'h177);
    end
    wrap_up;
  end
endmodule // mdpt_protect_tb
